// ===== hdl/axis_warning_pkg.sv
// Package with register map, warning codes and state types of the axis warning reporter.
package axis_warning_pkg;
    // ****************************************
    // Register map (word addresses)
    // ****************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_AX1_WARN_CODE = 4'h2;
    localparam logic [3:0] ADDR_AX2_WARN_CODE = 4'h3;
    localparam logic [3:0] ADDR_AX1_ERR_CODE = 4'h4;
    localparam logic [3:0] ADDR_AX2_ERR_CODE = 4'h5;
    localparam logic [3:0] ADDR_AX1_SPEED = 4'h6;
    localparam logic [3:0] ADDR_AX2_SPEED = 4'h7;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_AX1_CLEAR_BIT = 0;
    localparam int CTRL_AX2_CLEAR_BIT = 1;
    localparam int STAT_AX1_WARN_BIT = 0;
    localparam int STAT_AX2_WARN_BIT = 1;
    // ****************************************
    // Reset values and warning codes
    // ****************************************
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    localparam logic [15:0] WARN_SPEED_RANGE_AX1 = 16'd1020;
    localparam logic [15:0] WARN_SPEED_RANGE_AX2 = 16'd2020;
    localparam logic [15:0] WARN_TARGET_REJ_AX1 = 16'd1021;
    localparam logic [15:0] WARN_TARGET_REJ_AX2 = 16'd2021;
    localparam logic [15:0] WARN_SPEED_REJ_AX1 = 16'd1022;
    localparam logic [15:0] WARN_SPEED_REJ_AX2 = 16'd2022;
    // Control mode of an axis as reported by the motion core.
    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_POSITION = 2'b01,
        MODE_SPEED = 2'b11,
        MODE_ORIGIN = 2'b10
    } axis_mode_t;
endpackage : axis_warning_pkg

// ===== hdl/axis_warning_reporter.sv
// Two-axis warning and error reporter with speed clamping and request screening.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ns
module axis_warning_reporter
    import axis_warning_pkg::*;
#(
    parameter int SPEED_W = 32
) (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic SYS_RST,
    // Register port.
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Axis state from the motion core, one bit or field per axis.
    input wire logic [1:0] AXIS_MODE_1,
    input wire logic [1:0] AXIS_MODE_2,
    input wire logic [1:0] RAMPING,
    input wire logic [1:0] ZERO_SPEED,
    input wire logic [15:0] OP_STATUS_1,
    input wire logic [15:0] OP_STATUS_2,
    // Requests and speed settings per axis.
    input wire logic [1:0] SPEED_REQ,
    input wire logic [SPEED_W-1:0] SPEED_1,
    input wire logic [SPEED_W-1:0] SPEED_2,
    input wire logic [SPEED_W-1:0] BIAS_SPEED_1,
    input wire logic [SPEED_W-1:0] BIAS_SPEED_2,
    input wire logic [SPEED_W-1:0] SPEED_LIMIT_1,
    input wire logic [SPEED_W-1:0] SPEED_LIMIT_2,
    input wire logic [1:0] TARGET_CHANGE_REQ,
    input wire logic [1:0] SPEED_CHANGE_REQ,
    // Error events with their codes.
    input wire logic [1:0] ERR_EVENT,
    input wire logic [15:0] ERR_CODE_1,
    input wire logic [15:0] ERR_CODE_2,
    // Results to the motion core.
    output logic [SPEED_W-1:0] RUN_SPEED_1,
    output logic [SPEED_W-1:0] RUN_SPEED_2,
    output logic [1:0] TARGET_CHANGE_ACCEPT,
    output logic [1:0] SPEED_CHANGE_ACCEPT,
    output logic [1:0] WARN_FLAG,
    output logic [15:0] OP_STATUS_OUT_1,
    output logic [15:0] OP_STATUS_OUT_2
);

    // ****************************************
    // Behaviour overview
    // ****************************************
    // Each axis owns a warning flag, a warning code and an error code.
    // A warning never stops the axis: the motion core keeps its profile.
    // The only effect a warning has on motion is the speed clamp below.
    // A rejected request is simply not passed on as an acceptance pulse.
    // The warning code is always replaced by the newest warning.
    // The error code works the other way round and keeps the first error.
    // Software clears an axis by switching its clear command on.
    // Only the switch-on edge acts, so a command left on clears once.
    // To clear again, software writes zero first and then one.
    // A warning that arrives in the clearing cycle wins over the clear.
    // That way a warning that arrives in the clearing cycle itself is never lost.
    // An error that arrives in the clearing cycle also wins over the clear.
    // The two axes share no state, so one axis never disturbs the other.
    // The operation status words only pass through one register stage.
    // Nothing in this block ever writes into the operation status.
    // All outputs come from flip-flops, so the motion core sees clean levels.
    // The register port never stalls and answers one cycle after the strobe.
    // Read data fall back to zero in every cycle without a read strobe.
    // Unmapped addresses read as zero and ignore writes.
    // Speed values are unsigned and compared at their full width.
    // The clamp is continuous, not only at the moment of a request.
    // A range warning, however, is only raised when a speed is set or changed.
    // This keeps the warning code from being refreshed every cycle.
    // Requests are one-cycle pulses from the motion core.
    // A request held high for longer raises its warning in every cycle.

    // ****************************************
    // Per-axis views of the ports
    // ****************************************
    logic [SPEED_W-1:0] speed_in [2];
    logic [SPEED_W-1:0] bias_in [2];
    logic [SPEED_W-1:0] limit_in [2];
    logic [SPEED_W-1:0] run_speed_r [2];
    logic [15:0] err_in [2];
    logic [15:0] warn_code_r [2];
    logic [15:0] err_code_r [2];
    logic [1:0] err_held_r;
    logic [1:0] warn_flag_r;
    logic [1:0] clear_cmd_r;
    logic [1:0] clear_prev_r;
    logic [1:0] clear_rise;
    logic [1:0] tgt_acc_r;
    logic [1:0] spd_acc_r;
    axis_mode_t mode_in [2];
    logic [31:0] rdata_r;

    // Spread the per-axis inputs into arrays so the generate loop can index them.
    // Keeping one array per quantity lets the loop body stay identical per axis.
    // The mode field is cast to the enum so the screening compares named modes.
    assign speed_in[0] = SPEED_1;
    assign speed_in[1] = SPEED_2;
    assign bias_in[0] = BIAS_SPEED_1;
    assign bias_in[1] = BIAS_SPEED_2;
    assign limit_in[0] = SPEED_LIMIT_1;
    assign limit_in[1] = SPEED_LIMIT_2;
    assign err_in[0] = ERR_CODE_1;
    assign err_in[1] = ERR_CODE_2;
    assign mode_in[0] = axis_mode_t'(AXIS_MODE_1);
    assign mode_in[1] = axis_mode_t'(AXIS_MODE_2);

    // The clear command acts on the edge where software switches it on.
    // The edge memory starts at zero, matching the reset value of the command.
    // So no false clear edge follows the end of reset.
    assign clear_rise = clear_cmd_r & ~clear_prev_r;

    // ****************************************
    // Per-axis warning logic
    // ****************************************
    // One copy of the logic per axis; only the warning code values differ.
    // Axis one uses the thousand-series codes and axis two the two-thousand series.
    // The codes are held as plain binary numbers of their decimal value.
    for (genvar ax = 0; ax < 2; ax++) begin : g_axis
        localparam logic [15:0] CODE_SPD = (ax == 0) ? WARN_SPEED_RANGE_AX1 : WARN_SPEED_RANGE_AX2;
        localparam logic [15:0] CODE_TGT = (ax == 0) ? WARN_TARGET_REJ_AX1 : WARN_TARGET_REJ_AX2;
        localparam logic [15:0] CODE_SRJ = (ax == 0) ? WARN_SPEED_REJ_AX1 : WARN_SPEED_REJ_AX2;
        logic too_slow;
        logic too_fast;
        logic speed_warn;
        logic tgt_reject;
        logic spd_reject;
        logic any_warn;
        logic [15:0] code_nxt;

        // Speed range check on a set or newly requested speed.
        // The bias speed is the lowest allowed speed and the limit the highest.
        // Equal to either bound counts as in range.
        assign too_slow = speed_in[ax] < bias_in[ax];
        assign too_fast = speed_in[ax] > limit_in[ax];
        assign speed_warn = (SPEED_REQ[ax] | SPEED_CHANGE_REQ[ax]) & (too_slow | too_fast);

        // Request screening; a rejected request is dropped and the axis keeps going.
        // A target change needs position control and a moving axis.
        // A speed change is refused during origin return.
        // It is also refused while a position move is ramping.
        assign tgt_reject = TARGET_CHANGE_REQ[ax] &
            ((mode_in[ax] != MODE_POSITION) | ZERO_SPEED[ax]);
        assign spd_reject = SPEED_CHANGE_REQ[ax] & ((mode_in[ax] == MODE_ORIGIN) |
            ((mode_in[ax] == MODE_POSITION) & RAMPING[ax]));
        assign any_warn = speed_warn | tgt_reject | spd_reject;

        // Pick the newest code; a rejection outranks the range warning of the same request.
        always_comb begin
            if (spd_reject) begin
                code_nxt = CODE_SRJ;
            end else if (tgt_reject) begin
                code_nxt = CODE_TGT;
            end else begin
                code_nxt = CODE_SPD;
            end
        end

        // Warning flag: a new warning wins over a clear in the same cycle.
        always_ff @(posedge MCLK) begin
            if (SYS_RST) begin
                warn_flag_r[ax] <= 1'b0;
            end else if (any_warn) begin
                warn_flag_r[ax] <= 1'b1;
            end else if (clear_rise[ax]) begin
                warn_flag_r[ax] <= 1'b0;
            end
        end

        // Warning code always holds the latest warning.
        always_ff @(posedge MCLK) begin
            if (SYS_RST) begin
                warn_code_r[ax] <= CODE_RESET;
            end else if (any_warn) begin
                warn_code_r[ax] <= code_nxt;
            end else if (clear_rise[ax]) begin
                warn_code_r[ax] <= CODE_RESET;
            end
        end

        // Error code keeps the first error until cleared.
        // The held bit marks that a code is stored, even if the code is zero.
        // A clear in the same cycle as a new error is ignored.
        // Otherwise the error would vanish before software could see it.
        always_ff @(posedge MCLK) begin
            if (SYS_RST) begin
                err_code_r[ax] <= CODE_RESET;
                err_held_r[ax] <= 1'b0;
            end else if (ERR_EVENT[ax] & ~err_held_r[ax]) begin
                err_code_r[ax] <= err_in[ax];
                err_held_r[ax] <= 1'b1;
            end else if (clear_rise[ax] & ~ERR_EVENT[ax]) begin
                err_code_r[ax] <= CODE_RESET;
                err_held_r[ax] <= 1'b0;
            end // A further error while held leaves the code alone.
        end

        // Running speed is clamped to the violated bound; motion never stops here.
        // The low bound is tested first, so with a bias above the limit any speed below the bias gives the bias.
        // That case is a setting fault of the user and is not flagged here.
        always_ff @(posedge MCLK) begin
            if (SYS_RST) begin
                run_speed_r[ax] <= '0;
            end else if (too_slow) begin
                run_speed_r[ax] <= bias_in[ax];
            end else if (too_fast) begin
                run_speed_r[ax] <= limit_in[ax];
            end else begin
                run_speed_r[ax] <= speed_in[ax];
            end
        end

        // Acceptance pulses for requests that pass screening.
        // Each pulse is one cycle long and follows its request by one cycle.
        always_ff @(posedge MCLK) begin
            if (SYS_RST) begin
                tgt_acc_r[ax] <= 1'b0;
                spd_acc_r[ax] <= 1'b0;
            end else begin
                tgt_acc_r[ax] <= TARGET_CHANGE_REQ[ax] & ~tgt_reject;
                spd_acc_r[ax] <= SPEED_CHANGE_REQ[ax] & ~spd_reject;
            end
        end
    end

    // ****************************************
    // Register port
    // ****************************************
    // The control word carries one clear command bit per axis.
    // The status word carries one warning flag bit per axis.
    // Code words sit in the low 16 bits and their upper bits read zero; speed words return the running speed cast to 32 bits.
    // There are no wait states and no error responses.
    // Back-to-back strobes are taken one per cycle.
    // Control register write: one clear command bit per axis.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            clear_cmd_r <= 2'b00;
        end else if (WR && ADDR == ADDR_CTRL) begin
            clear_cmd_r[0] <= WDATA[CTRL_AX1_CLEAR_BIT];
            clear_cmd_r[1] <= WDATA[CTRL_AX2_CLEAR_BIT];
        end
    end

    // Edge memory of the clear command.
    // It lags the command by one cycle, so the clear acts one cycle after the write.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            clear_prev_r <= 2'b00;
        end else begin
            clear_prev_r <= clear_cmd_r;
        end
    end

    // Read data stand one cycle after the read strobe and are zero otherwise.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rdata_r <= READ_ZERO;
        end else if (RD) begin
            rdata_r <= READ_ZERO;
            unique case (ADDR)
                ADDR_CTRL: begin
                    rdata_r[CTRL_AX1_CLEAR_BIT] <= clear_cmd_r[0];
                    rdata_r[CTRL_AX2_CLEAR_BIT] <= clear_cmd_r[1];
                end
                ADDR_STATUS: begin
                    rdata_r[STAT_AX1_WARN_BIT] <= warn_flag_r[0];
                    rdata_r[STAT_AX2_WARN_BIT] <= warn_flag_r[1];
                end
                ADDR_AX1_WARN_CODE: rdata_r[15:0] <= warn_code_r[0];
                ADDR_AX2_WARN_CODE: rdata_r[15:0] <= warn_code_r[1];
                ADDR_AX1_ERR_CODE: rdata_r[15:0] <= err_code_r[0];
                ADDR_AX2_ERR_CODE: rdata_r[15:0] <= err_code_r[1];
                ADDR_AX1_SPEED: rdata_r <= 32'(run_speed_r[0]);
                ADDR_AX2_SPEED: rdata_r <= 32'(run_speed_r[1]);
                default: rdata_r <= READ_ZERO;
            endcase
        end else begin
            rdata_r <= READ_ZERO;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Operation status passes through untouched by any warning.
    // The stage only retimes the words so that they leave from flip-flops.
    // The copy is therefore one cycle late and otherwise identical.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            OP_STATUS_OUT_1 <= CODE_RESET;
            OP_STATUS_OUT_2 <= CODE_RESET;
        end else begin
            OP_STATUS_OUT_1 <= OP_STATUS_1;
            OP_STATUS_OUT_2 <= OP_STATUS_2;
        end
    end

    // Drive the ports from their registers.
    assign RDATA = rdata_r;
    assign RUN_SPEED_1 = run_speed_r[0];
    assign RUN_SPEED_2 = run_speed_r[1];
    assign TARGET_CHANGE_ACCEPT = tgt_acc_r;
    assign SPEED_CHANGE_ACCEPT = spd_acc_r;
    assign WARN_FLAG = warn_flag_r;

endmodule : axis_warning_reporter

// ===== sim/axis_warning_reporter_props.sv
// Checker on the top-level ports of the axis warning reporter.
`timescale 1ns/1ns
module axis_warning_props
    import axis_warning_pkg::*;
#(
    parameter int SPEED_W = 32
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [1:0] AXIS_MODE_1, AXIS_MODE_2, RAMPING, ZERO_SPEED, WARN_FLAG,
    input wire logic [1:0] SPEED_REQ, TARGET_CHANGE_REQ, SPEED_CHANGE_REQ,
    input wire logic [1:0] TARGET_CHANGE_ACCEPT, SPEED_CHANGE_ACCEPT,
    input wire logic [SPEED_W-1:0] SPEED_1, SPEED_2, BIAS_SPEED_1, SPEED_LIMIT_1, SPEED_LIMIT_2,
    input wire logic [SPEED_W-1:0] RUN_SPEED_1, RUN_SPEED_2,
    input wire logic [15:0] OP_STATUS_1, OP_STATUS_OUT_1, OP_STATUS_2, OP_STATUS_OUT_2
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // Request screening, clamping and status pass-through.
    a_range_flag: assert property (SPEED_REQ[0] && (SPEED_1 < BIAS_SPEED_1 || SPEED_1 > SPEED_LIMIT_1)
        |=> WARN_FLAG[0]) else $error("range warning flag missing");
    a_clamp_low: assert property (SPEED_1 < BIAS_SPEED_1 |=> RUN_SPEED_1 == $past(BIAS_SPEED_1))
        else $error("low speed not clamped");
    a_clamp_high: assert property (SPEED_2 > SPEED_LIMIT_2 |=> RUN_SPEED_2 == $past(SPEED_LIMIT_2))
        else $error("high speed not clamped");
    a_target_zero: assert property (TARGET_CHANGE_REQ[0] && ZERO_SPEED[0]
        |=> WARN_FLAG[0] && !TARGET_CHANGE_ACCEPT[0]) else $error("target change at zero speed taken");
    a_target_mode: assert property (TARGET_CHANGE_REQ[1] && AXIS_MODE_2 != MODE_POSITION
        |=> WARN_FLAG[1] && !TARGET_CHANGE_ACCEPT[1]) else $error("target change outside position taken");
    a_speed_origin: assert property (SPEED_CHANGE_REQ[0] && AXIS_MODE_1 == MODE_ORIGIN
        |=> WARN_FLAG[0] && !SPEED_CHANGE_ACCEPT[0]) else $error("speed change in origin return taken");
    a_speed_ramp: assert property (SPEED_CHANGE_REQ[0] && AXIS_MODE_1 == MODE_POSITION && RAMPING[0]
        |=> WARN_FLAG[0] && !SPEED_CHANGE_ACCEPT[0]) else $error("speed change while ramping taken");
    a_status_copy: assert property (!$past(SYS_RST) |-> OP_STATUS_OUT_1 == $past(OP_STATUS_1))
        else $error("operation status altered");
    a_status_copy2: assert property (!$past(SYS_RST) |-> OP_STATUS_OUT_2 == $past(OP_STATUS_2))
        else $error("axis two operation status altered");
    a_target_accept: assert property (TARGET_CHANGE_REQ[0] && AXIS_MODE_1 == MODE_POSITION && !ZERO_SPEED[0]
        |=> TARGET_CHANGE_ACCEPT[0]) else $error("valid target change not accepted");
    a_speed_accept: assert property (SPEED_CHANGE_REQ[1] && AXIS_MODE_2 == MODE_IDLE
        |=> SPEED_CHANGE_ACCEPT[1]) else $error("valid speed change not accepted");
endmodule : axis_warning_props

bind axis_warning_reporter axis_warning_props #(.SPEED_W(SPEED_W)) props_i (.*);

// ===== sim/axis_motion_model.sv
// Behavioural motion core that feeds axis state to the reporter.
`timescale 1ns/1ns
module axis_motion_model (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [1:0] mode1, mode2, ramp, zero,
    output logic [1:0] AXIS_MODE_1, AXIS_MODE_2, RAMPING, ZERO_SPEED,
    output logic [15:0] OP_STATUS_1, OP_STATUS_2
);
    // Axis state follows the commanded profile one cycle later.
    always_ff @(posedge MCLK) begin
        AXIS_MODE_1 <= SYS_RST ? 2'h0 : mode1;
        AXIS_MODE_2 <= SYS_RST ? 2'h0 : mode2;
        RAMPING <= SYS_RST ? 2'h0 : ramp;
        ZERO_SPEED <= SYS_RST ? 2'h0 : zero;
    end
    // Status words move every cycle, so a frozen or altered copy shows.
    always_ff @(posedge MCLK) begin
        OP_STATUS_1 <= SYS_RST ? 16'h0 : OP_STATUS_1 + 16'h1;
        OP_STATUS_2 <= SYS_RST ? 16'h0 : OP_STATUS_2 - 16'h3;
    end
endmodule : axis_motion_model

// ===== sim/tb_axis_warning_reporter.sv
// Self-checking testbench of the axis warning reporter.
`timescale 1ns/1ns
module tb_axis_warning_reporter;
    import axis_warning_pkg::*;
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0;
    logic [31:0] RDATA, RUN_SPEED_1, RUN_SPEED_2;
    logic [31:0] SPEED_1 = 32'h0, SPEED_2 = 32'h1f4, BIAS_SPEED_1 = 32'h64, BIAS_SPEED_2 = 32'h64;
    logic [31:0] SPEED_LIMIT_1 = 32'h3e8, SPEED_LIMIT_2 = 32'h3e8;
    logic [15:0] ERR_CODE_1 = 16'h0, ERR_CODE_2 = 16'h0;
    logic [15:0] OP_STATUS_1, OP_STATUS_2, OP_STATUS_OUT_1, OP_STATUS_OUT_2;
    logic [1:0] mode1 = 2'h0, mode2 = 2'h0, ramp = 2'h0, zero = 2'h0;
    logic [1:0] AXIS_MODE_1, AXIS_MODE_2, RAMPING, ZERO_SPEED, WARN_FLAG;
    logic [1:0] TARGET_CHANGE_ACCEPT, SPEED_CHANGE_ACCEPT;
    logic [1:0] SPEED_REQ, TARGET_CHANGE_REQ, SPEED_CHANGE_REQ, ERR_EVENT;
    logic [7:0] pulses = 8'h0;
    int failures = 0;
    int comparisons = 0;
    // Request pulses come from one byte: start, target, speed change, error.
    assign {ERR_EVENT, SPEED_CHANGE_REQ, TARGET_CHANGE_REQ, SPEED_REQ} = pulses;
    axis_warning_reporter dut (.*);
    axis_motion_model core (.*);
    // Free-running 100 MHz clock.
    always #5 MCLK = ~MCLK;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge MCLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge MCLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 chk(RDATA, e);
    endtask : rd
    task automatic pulse(input logic [7:0] p);
        @(posedge MCLK);
        pulses <= p;
        @(posedge MCLK);
        pulses <= 8'h0;
    endtask : pulse
    task automatic results;
        if (failures == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    // Main sequence: reset, screening of each request kind, clear and error hold.
    initial begin
        repeat (12) @(posedge MCLK);
        SYS_RST <= 1'b0;
        rd(ADDR_STATUS, READ_ZERO);
        wr(4'hf, 32'hffff_ffff);
        rd(4'hf, READ_ZERO);
        mode1 <= MODE_POSITION;
        SPEED_1 <= 32'h1f4;
        pulse(8'h01);
        rd(ADDR_STATUS, READ_ZERO);
        pulse(8'h04);
        rd(ADDR_STATUS, READ_ZERO);
        pulse(8'h20);
        rd(ADDR_STATUS, READ_ZERO);
        rd(ADDR_AX1_SPEED, 32'h1f4);
        SPEED_1 <= 32'h0a;
        pulse(8'h01);
        rd(ADDR_AX1_WARN_CODE, {16'h0, WARN_SPEED_RANGE_AX1});
        rd(ADDR_AX1_SPEED, BIAS_SPEED_1);
        rd(ADDR_STATUS, 32'h1);
        rd(ADDR_AX2_WARN_CODE, READ_ZERO);
        zero <= 2'h1;
        pulse(8'h04);
        rd(ADDR_AX1_WARN_CODE, {16'h0, WARN_TARGET_REJ_AX1});
        zero <= 2'h0;
        ramp <= 2'h1;
        pulse(8'h10);
        rd(ADDR_AX1_WARN_CODE, {16'h0, WARN_SPEED_REJ_AX1});
        ramp <= 2'h0;
        mode1 <= MODE_ORIGIN;
        pulse(8'h04);
        rd(ADDR_AX1_WARN_CODE, {16'h0, WARN_TARGET_REJ_AX1});
        pulse(8'h10);
        rd(ADDR_AX1_WARN_CODE, {16'h0, WARN_SPEED_REJ_AX1});
        pulse(8'h08);
        rd(ADDR_AX2_WARN_CODE, {16'h0, WARN_TARGET_REJ_AX2});
        SPEED_2 <= 32'h7d0;
        pulse(8'h02);
        rd(ADDR_AX2_WARN_CODE, {16'h0, WARN_SPEED_RANGE_AX2});
        rd(ADDR_AX2_SPEED, SPEED_LIMIT_2);
        SPEED_1 <= 32'h1f4;
        wr(ADDR_CTRL, 32'h1);
        rd(ADDR_AX2_WARN_CODE, {16'h0, WARN_SPEED_RANGE_AX2});
        rd(ADDR_STATUS, 32'h2);
        rd(ADDR_AX1_WARN_CODE, READ_ZERO);
        wr(ADDR_CTRL, 32'h0);
        ERR_CODE_1 <= 16'd1500;
        pulse(8'h40);
        ERR_CODE_1 <= 16'd1501;
        pulse(8'h40);
        rd(ADDR_AX1_ERR_CODE, 32'd1500);
        results();
    end
endmodule : tb_axis_warning_reporter
